// File: rtl/eeu_params.svh
// Purpose: constants for the exception entry and return unit
// Assumes: status word holds mode in [4:0], T in [5], F in [6], I in [7]
// Notes: included by the unit and its package users
`ifndef EEU_PARAMS_SVH
`define EEU_PARAMS_SVH
// mode field codes
`define EEU_MODE_USR 5'h10
`define EEU_MODE_FIQ 5'h11
`define EEU_MODE_IRQ 5'h12
`define EEU_MODE_SVC 5'h13
`define EEU_MODE_ABT 5'h17
`define EEU_MODE_UND 5'h1B
`define EEU_MODE_SYS 5'h1F
// status word bit positions
`define EEU_BIT_T 5
`define EEU_BIT_F 6
`define EEU_BIT_I 7
`define EEU_MODE_MSB 4
// status after reset: supervisor, both masks set, T clear
`define EEU_PSR_RST 32'h000000D3
// vector bases and offsets
`define EEU_VBASE_LO 32'h00000000
`define EEU_VBASE_HI 32'hFFFF0000
`define EEU_VEC_RST 32'h00000000
`define EEU_VEC_UND 32'h00000004
`define EEU_VEC_SWI 32'h00000008
`define EEU_VEC_PREFETCH_ABORT_EXC 32'h0000000C
`define EEU_VEC_DATA_ABORT_EXC 32'h00000010
`define EEU_VEC_IRQ 32'h00000018
`define EEU_VEC_FIQ 32'h0000001C
// link offsets
`define EEU_LOFF_2 32'h00000002
`define EEU_LOFF_4 32'h00000004
`define EEU_LOFF_8 32'h00000008
// banked saved status slots and their indices
`define EEU_NBANK 5
`define EEU_BK_FIQ 3'h0
`define EEU_BK_IRQ 3'h1
`define EEU_BK_SVC 3'h2
`define EEU_BK_ABT 3'h3
`define EEU_BK_UND 3'h4
`endif

// File: rtl/eeu_pkg.sv
// Purpose: types for the exception entry and return unit
// Assumes: nothing
// Notes: states are Gray coded along reset -> vector -> run
package eeu_pkg;
  typedef enum logic [3:0] {
    EXC_NONE = 4'h0,
    EXC_RST  = 4'h1,
    EXC_UND  = 4'h2,
    EXC_SWI  = 4'h3,
    EXC_PREFETCH_ABORT_EXC = 4'h4,
    EXC_DATA_ABORT_EXC = 4'h5,
    EXC_IRQ  = 4'h6,
    EXC_FIQ  = 4'h7,
    EXC_BREAKPOINT_INSTR = 4'h8
  } eeu_exc_t;
  typedef enum logic [1:0] {
    ST_RST = 2'h0,
    ST_VEC = 2'h1,
    ST_RUN = 2'h3
  } eeu_state_t;
endpackage

// File: rtl/eeu_unit.sv
// Purpose: exception entry, vector redirect and status restore
// Assumes: pipeline strobes are synchronous one-cycle pulses
// Notes: entries are taken only at instruction end, in state run
`timescale 1ns/1ps
`include "eeu_params.svh"
module eeu_unit
  import eeu_pkg::*;
(
  input  wire logic        core_clk,             // core clock
  input  wire logic        nrst,                 // async reset, low active
  input  wire logic        clk_en,               // freezes state when low
  input  wire logic        high_vector_select,   // vector base choice
  input  wire logic        fast_irq_low_input,   // fast request, low active
  input  wire logic        normal_irq_low_input, // normal request, low active
  input  wire logic        fetch_done,           // end of instruction fetch
  input  wire logic        fetch_abort_input,    // fetch failed
  input  wire logic        pipe_adv,             // decode moves to execute
  input  wire logic        pipe_flush,           // branch flushes pipeline
  input  wire logic        data_done,            // end of data access
  input  wire logic        transfer_abort_input, // data access failed
  input  wire logic        instr_end,            // end of executing instruction
  input  wire logic        exec_valid,           // execute stage holds an instr
  input  wire logic        exec_pass,            // its condition passed
  input  wire logic        exec_swi,             // it is a software trap
  input  wire logic        exec_undefined_trap,           // it is undefined
  input  wire logic        exec_breakpoint_instr,            // it is a breakpoint
  input  wire logic [31:0] exec_addr,            // address of executing instr
  input  wire logic [31:0] next_pc,              // address of next, skipped instr
  input  wire logic        restore_req,          // flag-setting write to pc
  input  wire logic        psr_ctl_wr,           // write of status control byte
  input  wire logic [7:0]  psr_ctl_wdata,        // control byte data
  output logic [31:0]      current_status_word,  // current status
  output logic [31:0]      saved_status_word,    // saved status of current mode
  output logic             link_we,              // write mode link register
  output logic [4:0]       link_mode,            // mode of that link register
  output logic [31:0]      link_value,           // value to write
  output logic             redirect,             // fetch redirect pulse
  output logic [31:0]      redirect_addr,        // vector address
  output logic             fiq_bank_sel,         // fast banked regs in use while T is clear
  output logic             abandon               // kill executing instruction, high only in reset
);

  // bank slot of a privileged mode
  function automatic logic [2:0] bank_idx(input logic [4:0] m);
    case (m)
      `EEU_MODE_FIQ: bank_idx = `EEU_BK_FIQ;
      `EEU_MODE_IRQ: bank_idx = `EEU_BK_IRQ;
      `EEU_MODE_ABT: bank_idx = `EEU_BK_ABT;
      `EEU_MODE_UND: bank_idx = `EEU_BK_UND;
      default:       bank_idx = `EEU_BK_SVC;
    endcase
  endfunction

  // mode that has a saved status
  function automatic logic has_saved_status_word(input logic [4:0] m);
    has_saved_status_word = (m == `EEU_MODE_FIQ) || (m == `EEU_MODE_IRQ) ||
               (m == `EEU_MODE_SVC) || (m == `EEU_MODE_ABT) ||
               (m == `EEU_MODE_UND);
  endfunction

  function automatic logic [4:0] exc_mode(input eeu_exc_t e);
    case (e)
      EXC_UND:  exc_mode = `EEU_MODE_UND;
      EXC_PREFETCH_ABORT_EXC: exc_mode = `EEU_MODE_ABT;
      EXC_DATA_ABORT_EXC: exc_mode = `EEU_MODE_ABT;
      EXC_BREAKPOINT_INSTR: exc_mode = `EEU_MODE_ABT;
      EXC_IRQ:  exc_mode = `EEU_MODE_IRQ;
      EXC_FIQ:  exc_mode = `EEU_MODE_FIQ;
      default:  exc_mode = `EEU_MODE_SVC;
    endcase
  endfunction

  // vector offset of each exception
  function automatic logic [31:0] vec_off(input eeu_exc_t e);
    case (e)
      EXC_UND:  vec_off = `EEU_VEC_UND;
      EXC_SWI:  vec_off = `EEU_VEC_SWI;
      EXC_PREFETCH_ABORT_EXC: vec_off = `EEU_VEC_PREFETCH_ABORT_EXC;
      EXC_BREAKPOINT_INSTR: vec_off = `EEU_VEC_PREFETCH_ABORT_EXC;
      EXC_DATA_ABORT_EXC: vec_off = `EEU_VEC_DATA_ABORT_EXC;
      EXC_IRQ:  vec_off = `EEU_VEC_IRQ;
      EXC_FIQ:  vec_off = `EEU_VEC_FIQ;
      default:  vec_off = `EEU_VEC_RST;
    endcase
  endfunction

  // link offset by exception and instruction state
  function automatic logic [31:0] link_off(input eeu_exc_t e, input logic t);
    case (e)
      EXC_DATA_ABORT_EXC: link_off = `EEU_LOFF_8;
      EXC_SWI:  link_off = t ? `EEU_LOFF_2 : `EEU_LOFF_4;
      EXC_UND:  link_off = t ? `EEU_LOFF_2 : `EEU_LOFF_4;
      default:  link_off = `EEU_LOFF_4;
    endcase
  endfunction

  logic             rst_m_r;
  logic             rst_q;
  eeu_state_t       st_r;
  eeu_exc_t         exc_r;
  logic [31:0]      status_r;
  logic [31:0]      saved_status_word_r [`EEU_NBANK];
  logic             fiq_q_r;
  logic             irq_q_r;
  logic             tag_dec_r;
  logic             tag_exe_r;
  logic             data_abort_exc_pend_r;
  logic [31:0]      data_abort_exc_addr_r;
  logic [31:0]      saved_status_word_rd_r;
  logic             link_we_r;
  logic [4:0]       link_mode_r;
  logic [31:0]      link_val_r;
  logic             redirect_r;
  logic [31:0]      redirect_addr_r;
  logic             fiq_bank_r;
  logic             abandon_r;

  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_m_r <= 1'b0;
      rst_q   <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_q   <= rst_m_r;
    end
  end

  // decode of the pending exception
  wire [4:0]  cur_mode   = status_r[`EEU_MODE_MSB:0];
  wire        cur_t      = status_r[`EEU_BIT_T];
  wire        priv       = cur_mode != `EEU_MODE_USR;
  wire        exec_go    = exec_valid && exec_pass;
  wire        fiq_ok     = !status_r[`EEU_BIT_F] && !fiq_q_r;
  wire        irq_ok     = !status_r[`EEU_BIT_I] && !irq_q_r;
  wire        prefetch_abort_exc_ok    = exec_valid && tag_exe_r;
  wire eeu_exc_t exc_sel =
    data_abort_exc_pend_r            ? EXC_DATA_ABORT_EXC :
    fiq_ok                 ? EXC_FIQ  :
    irq_ok                 ? EXC_IRQ  :
    prefetch_abort_exc_ok                ? EXC_PREFETCH_ABORT_EXC :
    (exec_go && exec_breakpoint_instr) ? EXC_BREAKPOINT_INSTR :
    (exec_go && exec_undefined_trap)? EXC_UND  :
    (exec_go && exec_swi)  ? EXC_SWI  : EXC_NONE;
  wire        take       = (st_r == ST_RUN) && instr_end && (exc_sel != EXC_NONE);
  wire [4:0]  new_mode   = exc_mode(exc_sel);
  wire [31:0] link_base  = (exc_sel == EXC_DATA_ABORT_EXC) ? data_abort_exc_addr_r :
                           ((exc_sel == EXC_IRQ) || (exc_sel == EXC_FIQ)) ?
                           next_pc : exec_addr;
  wire [31:0] link_nxt   = link_base + link_off(exc_sel, cur_t);
  wire [31:0] vbase      = high_vector_select ? `EEU_VBASE_HI : `EEU_VBASE_LO;
  wire [31:0] saved_status_word_cur   = saved_status_word_r[bank_idx(cur_mode)];
  wire        do_restore = (st_r == ST_RUN) && !take && restore_req && has_saved_status_word(cur_mode);
  wire        do_ctl     = (st_r == ST_RUN) && !take && !restore_req && psr_ctl_wr && priv;
  wire [31:0] ctl_val    = {status_r[31:8], psr_ctl_wdata[7:6], cur_t, psr_ctl_wdata[4:0]};
  wire        f_nxt      = status_r[`EEU_BIT_F] || (exc_sel == EXC_FIQ);
  wire [31:0] entry_val  = {status_r[31:8], 1'b1, f_nxt, cur_t, new_mode};

  always_ff @(posedge core_clk)
  begin
    if (clk_en && take)
      saved_status_word_r[bank_idx(new_mode)] <= status_r;
  end

  // state, status word and outputs
  always_ff @(posedge core_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      st_r            <= ST_RST;
      exc_r           <= EXC_RST;
      status_r        <= `EEU_PSR_RST;
      link_we_r       <= 1'b0;
      link_mode_r     <= `EEU_MODE_SVC;
      link_val_r      <= `EEU_VBASE_LO;
      redirect_r      <= 1'b0;
      redirect_addr_r <= `EEU_VBASE_LO;
      abandon_r       <= 1'b1;
    end
    else if (clk_en)
    begin
      link_we_r  <= 1'b0;
      redirect_r <= 1'b0;
      abandon_r  <= 1'b0;
      case (st_r)
        ST_RST:
        begin
          exc_r <= EXC_RST;
          st_r  <= ST_VEC;
        end
        ST_VEC:
        begin
          redirect_r      <= 1'b1;
          redirect_addr_r <= vbase | vec_off(exc_r);
          status_r[`EEU_BIT_T] <= 1'b0;
          st_r            <= ST_RUN;
        end
        ST_RUN:
        begin
          if (take)
          begin
            status_r    <= entry_val;
            exc_r       <= exc_sel;
            link_we_r   <= 1'b1;
            link_mode_r <= new_mode;
            link_val_r  <= link_nxt;
            st_r        <= ST_VEC;
          end
          else if (do_restore)
            status_r <= saved_status_word_cur;
          else if (do_ctl)
            status_r <= ctl_val;
        end
        default:
          st_r <= ST_RST;
      endcase
    end
  end

  // input capture, abort tags and readback
  always_ff @(posedge core_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      fiq_q_r     <= 1'b1;
      irq_q_r     <= 1'b1;
      tag_dec_r   <= 1'b0;
      tag_exe_r   <= 1'b0;
      data_abort_exc_pend_r <= 1'b0;
      data_abort_exc_addr_r <= `EEU_VBASE_LO;
      saved_status_word_rd_r   <= `EEU_VBASE_LO;
      fiq_bank_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      fiq_q_r   <= fast_irq_low_input;
      irq_q_r   <= normal_irq_low_input;
      saved_status_word_rd_r <= saved_status_word_cur;
      fiq_bank_r <= (cur_mode == `EEU_MODE_FIQ) && !cur_t;
      // fetch abort tag follows the instruction
      if (pipe_flush || take)
      begin
        tag_dec_r <= 1'b0;
        tag_exe_r <= 1'b0;
      end
      else
      begin
        if (fetch_done)
          tag_dec_r <= fetch_abort_input;
        if (pipe_adv)
          tag_exe_r <= tag_dec_r;
      end
      // transfer abort sampled; new event beats the clear
      if (data_done && transfer_abort_input)
      begin
        data_abort_exc_pend_r <= 1'b1;
        data_abort_exc_addr_r <= exec_addr;
      end
      else if (take && (exc_sel == EXC_DATA_ABORT_EXC))
        data_abort_exc_pend_r <= 1'b0;
    end
  end

  assign current_status_word = status_r;
  assign saved_status_word   = saved_status_word_rd_r;
  assign link_we             = link_we_r;
  assign link_mode           = link_mode_r;
  assign link_value          = link_val_r;
  assign redirect            = redirect_r;
  assign redirect_addr       = redirect_addr_r;
  assign fiq_bank_sel        = fiq_bank_r;
  assign abandon             = abandon_r;

  // checks on the enabled clock
  default clocking cb @(posedge core_clk iff clk_en);
  endclocking
  default disable iff (!rst_q);

  sequence s_entry;
    take;
  endsequence
  sequence s_vector;
    ##1 (st_r == ST_VEC) ##1 (redirect_r && !status_r[`EEU_BIT_T]);
  endsequence

  a_vector_after_entry: assert property (s_entry |-> s_vector)
    else $error("vector redirect did not follow entry");
  a_fiq_both_masks: assert property (
    take && (exc_sel == EXC_FIQ) |=> status_r[`EEU_BIT_I] && status_r[`EEU_BIT_F]
      && (status_r[`EEU_MODE_MSB:0] == `EEU_MODE_FIQ))
    else $error("fast entry left a mask clear");
  a_irq_mask_only: assert property (
    take && (exc_sel == EXC_IRQ) |=> status_r[`EEU_BIT_I]
      && (status_r[`EEU_BIT_F] == $past(status_r[`EEU_BIT_F])))
    else $error("normal entry masks wrong");
  a_abort_masks: assert property (
    take && ((exc_sel == EXC_PREFETCH_ABORT_EXC) || (exc_sel == EXC_DATA_ABORT_EXC)) |=>
      status_r[`EEU_BIT_I] && (status_r[`EEU_MODE_MSB:0] == `EEU_MODE_ABT))
    else $error("abort entry mode or mask wrong");
  a_status_saved: assert property (
    take |=> saved_status_word_r[bank_idx(status_r[`EEU_MODE_MSB:0])] == $past(status_r))
    else $error("status not saved on entry");
  a_data_abort_exc_link: assert property (
    link_we_r && (exc_r == EXC_DATA_ABORT_EXC) |-> link_val_r == $past(data_abort_exc_addr_r) + `EEU_LOFF_8)
    else $error("data abort link value wrong");
  a_fiq_over_irq: assert property (
    take && fiq_ok && irq_ok && !data_abort_exc_pend_r |=> status_r[`EEU_MODE_MSB:0] == `EEU_MODE_FIQ)
    else $error("fast request lost priority");
  a_restore_status: assert property (
    do_restore |=> status_r == $past(saved_status_word_cur))
    else $error("status not restored");
  a_reset_vector: assert property (
    (st_r == ST_RST) |-> ##2 redirect_r && (redirect_addr_r == vbase))
    else $error("reset vector not fetched");
  a_fiq_registered: assert property (
    ##1 fiq_q_r == $past(fast_irq_low_input))
    else $error("fast request not registered");
endmodule

// File: verif/eeu_src_model.sv
// Purpose: interrupt sources and memory abort signalling for the exception unit
// Assumes: driven from the bench by task calls, one edge per call step
// Notes: abort lines carry noise outside their done strobes
`timescale 1ns/1ps
module eeu_src_model (
  input  wire logic core_clk,             // core clock
  output logic      fast_irq_low_input,   // fast request, low active
  output logic      normal_irq_low_input, // normal request, low active
  output logic      fetch_done,           // end of fetch strobe
  output logic      fetch_abort_input,    // fetch failed
  output logic      data_done,            // end of data access strobe
  output logic      transfer_abort_input  // data access failed
);
  // idle: no requests, no strobes
  initial
  begin
    fast_irq_low_input   = 1'b1;
    normal_irq_low_input = 1'b1;
    fetch_done           = 1'b0;
    fetch_abort_input    = 1'b1;
    data_done            = 1'b0;
    transfer_abort_input = 1'b1;
  end
  task automatic set_req(input logic fast_low, input logic norm_low);
    @(posedge core_clk);
    fast_irq_low_input   <= fast_low;
    normal_irq_low_input <= norm_low;
  endtask
  task automatic fetch_end(input logic abt);
    @(posedge core_clk);
    fetch_done        <= 1'b1;
    fetch_abort_input <= abt;
    @(posedge core_clk);
    fetch_done        <= 1'b0;
    fetch_abort_input <= ~abt; // not meaningful outside the strobe
  endtask
  task automatic data_end(input logic abt);
    @(posedge core_clk);
    data_done            <= 1'b1;
    transfer_abort_input <= abt;
    @(posedge core_clk);
    data_done            <= 1'b0;
    transfer_abort_input <= ~abt; // not meaningful outside the strobe
  endtask
endmodule

// File: verif/eeu_unit_test.sv
// Purpose: self-checking bench for the exception entry and return unit
// Assumes: 200 MHz core clock, request inputs from the source model
// Notes: the unused 2-bit state code 2'h2 cannot be reached through these ports
`timescale 1ns/1ps
`include "eeu_params.svh"
module eeu_unit_test;
  import eeu_pkg::*;
  logic core_clk, nrst, clk_en, high_vector_select, pipe_adv, pipe_flush, instr_end;
  logic exec_valid, exec_pass, exec_swi, exec_undefined_trap, exec_breakpoint_instr, restore_req, psr_ctl_wr;
  logic fiq_n, irq_n, fetch_done, fetch_abort, data_done, xfer_abort;
  logic [31:0] exec_addr, next_pc, status, saved, link_value, redirect_addr;
  logic [7:0]  psr_ctl_wdata;
  logic [4:0]  link_mode;
  logic        link_we, redirect, fiq_bank_sel, abandon;
  int          errors, samples_checked, n;
  eeu_exc_t    kinds [8] = '{EXC_SWI, EXC_UND, EXC_BREAKPOINT_INSTR, EXC_PREFETCH_ABORT_EXC, EXC_DATA_ABORT_EXC, EXC_IRQ, EXC_FIQ,
                             EXC_SWI};

  eeu_unit uut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .high_vector_select(high_vector_select), .fast_irq_low_input(fiq_n),
    .normal_irq_low_input(irq_n), .fetch_done(fetch_done), .fetch_abort_input(fetch_abort),
    .pipe_adv(pipe_adv), .pipe_flush(pipe_flush), .data_done(data_done),
    .transfer_abort_input(xfer_abort), .instr_end(instr_end), .exec_valid(exec_valid),
    .exec_pass(exec_pass), .exec_swi(exec_swi), .exec_undefined_trap(exec_undefined_trap),
    .exec_breakpoint_instr(exec_breakpoint_instr), .exec_addr(exec_addr), .next_pc(next_pc),
    .restore_req(restore_req), .psr_ctl_wr(psr_ctl_wr), .psr_ctl_wdata(psr_ctl_wdata),
    .current_status_word(status), .saved_status_word(saved), .link_we(link_we),
    .link_mode(link_mode), .link_value(link_value), .redirect(redirect),
    .redirect_addr(redirect_addr), .fiq_bank_sel(fiq_bank_sel), .abandon(abandon));

  eeu_src_model model (.core_clk(core_clk), .fast_irq_low_input(fiq_n),
    .normal_irq_low_input(irq_n), .fetch_done(fetch_done), .fetch_abort_input(fetch_abort),
    .data_done(data_done), .transfer_abort_input(xfer_abort));

  // free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one-cycle instruction end with the decode of the executing instruction
  task automatic end_instr(input logic sw, input logic un, input logic bk);
    @(posedge core_clk);
    instr_end <= 1'b1;
    exec_swi  <= sw;
    exec_undefined_trap <= un;
    exec_breakpoint_instr <= bk;
    @(posedge core_clk);
    instr_end <= 1'b0;
    exec_swi  <= 1'b0;
    exec_undefined_trap <= 1'b0;
    exec_breakpoint_instr <= 1'b0;
  endtask

  // single-cycle strobe of control byte write, restore, advance or flush
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge core_clk);
    psr_ctl_wr    <= (which == 0);
    psr_ctl_wdata <= d;
    restore_req   <= (which == 1);
    pipe_adv      <= (which == 2);
    pipe_flush    <= (which == 3);
    @(posedge core_clk);
    {psr_ctl_wr, restore_req, pipe_adv, pipe_flush} <= 4'h0;
    #1;
  endtask

  // no entry may start for four cycles
  task automatic quiet(input string what);
    logic seen;
    seen = 1'b0;
    repeat (4)
    begin
      #1 seen = seen | (link_we !== 1'b0) | (redirect !== 1'b0);
      @(posedge core_clk);
    end
    chk(seen, 1'b0, what);
    $display("test %s done", what);
  endtask

  task automatic run_exc(input eeu_exc_t k, input logic hv);
    logic [4:0]  m;
    logic [31:0] lv;
    logic [31:0] va;
    logic        f;
    logic [31:0] ra;
    logic [31:0] ro;
    lv = (k == EXC_IRQ || k == EXC_FIQ) ? 32'h00001004 : 32'h00001000;
    lv = lv + ((k == EXC_DATA_ABORT_EXC) ? `EEU_LOFF_8 : `EEU_LOFF_4);
    case (k)
      EXC_SWI:  begin m = `EEU_MODE_SVC; va = `EEU_VEC_SWI; end
      EXC_UND:  begin m = `EEU_MODE_UND; va = `EEU_VEC_UND; end
      EXC_IRQ:  begin m = `EEU_MODE_IRQ; va = `EEU_VEC_IRQ; end
      EXC_FIQ:  begin m = `EEU_MODE_FIQ; va = `EEU_VEC_FIQ; end
      EXC_DATA_ABORT_EXC: begin m = `EEU_MODE_ABT; va = `EEU_VEC_DATA_ABORT_EXC; end
      default:  begin m = `EEU_MODE_ABT; va = `EEU_VEC_PREFETCH_ABORT_EXC; end
    endcase
    va = va + (hv ? `EEU_VBASE_HI : `EEU_VBASE_LO);
    f = (k == EXC_FIQ);
    ra = (k == EXC_PREFETCH_ABORT_EXC || k == EXC_BREAKPOINT_INSTR || k == EXC_DATA_ABORT_EXC) ? 32'h00001000 : 32'h00001004;
    ro = (k == EXC_DATA_ABORT_EXC) ? `EEU_LOFF_8 : (k == EXC_SWI || k == EXC_UND) ? 32'h0 : `EEU_LOFF_4;
    strobe(0, 8'h13);
    high_vector_select <= hv;
    exec_addr <= 32'h00001000;
    next_pc   <= 32'h00001004;
    if (k == EXC_FIQ) model.set_req(1'b0, 1'b0);
    if (k == EXC_IRQ) model.set_req(1'b1, 1'b0);
    if (k == EXC_DATA_ABORT_EXC) model.set_req(1'b0, 1'b1);
    if (k == EXC_DATA_ABORT_EXC) model.data_end(1'b1);
    if (k == EXC_PREFETCH_ABORT_EXC) model.fetch_end(1'b1);
    if (k == EXC_PREFETCH_ABORT_EXC) strobe(2, 8'h00);
    repeat (2) @(posedge core_clk);
    end_instr(k == EXC_SWI, k == EXC_UND, k == EXC_BREAKPOINT_INSTR);
    #1 chk(link_we, 1'b1, "link write");
    chk(link_value, lv, "link value");
    chk(link_value - ro, ra, "return address");
    chk(link_mode, m, "link mode");
    chk(status, {24'h0, 1'b1, f, 1'b0, m}, "entry status");
    @(posedge core_clk);
    #1 chk(redirect, 1'b1, "redirect");
    chk(redirect_addr, va, "vector");
    chk(status[`EEU_BIT_T], 1'b0, "state bit");
    chk(saved, 32'h00000013, "saved status");
    chk(fiq_bank_sel, f, "fast bank");
    model.set_req(1'b1, 1'b1);
    repeat (2) @(posedge core_clk);
    strobe(1, 8'h00);
    chk(status, 32'h00000013, "restore");
    $display("test entry %s done", k.name());
  endtask

  initial
  begin
    {nrst, high_vector_select, pipe_adv, pipe_flush, instr_end} = 5'h00;
    {exec_swi, exec_undefined_trap, exec_breakpoint_instr, restore_req, psr_ctl_wr} = 5'h00;
    {clk_en, exec_valid, exec_pass} = 3'h7;
    psr_ctl_wdata = 8'h00;
    exec_addr = 32'h0;
    next_pc = 32'h0;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge core_clk);
    #1 chk(abandon, 1'b1, "abandon in reset");
    chk(status, `EEU_PSR_RST, "reset status");
    @(posedge core_clk);
    nrst <= 1'b1;
    n = 0;
    while (redirect !== 1'b1 && n < 8)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(redirect, 1'b1, "reset redirect");
    chk(redirect_addr, `EEU_VBASE_LO + `EEU_VEC_RST, "reset vector");
    chk(abandon, 1'b0, "abandon released");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      run_exc(kinds[i], i == 7);
    strobe(0, 8'h93);
    model.set_req(1'b1, 1'b0);
    repeat (2) @(posedge core_clk);
    end_instr(1'b0, 1'b0, 1'b0);
    quiet("normal masked");
    model.set_req(1'b1, 1'b1);
    strobe(0, 8'h13);
    fork
      model.set_req(1'b0, 1'b1);
      end_instr(1'b0, 1'b0, 1'b0);
    join
    quiet("fast registered");
    model.set_req(1'b1, 1'b1);
    model.fetch_end(1'b1);
    strobe(2, 8'h00);
    strobe(3, 8'h00);
    end_instr(1'b0, 1'b0, 1'b0);
    quiet("flushed abort");
    clk_en <= 1'b0;
    end_instr(1'b1, 1'b0, 1'b0);
    clk_en <= 1'b1;
    quiet("clock held");
    strobe(0, 8'h10);
    chk(status, 32'h00000010, "user mode");
    strobe(1, 8'h00);
    chk(status, 32'h00000010, "user restore");
    strobe(0, 8'h13);
    chk(status, 32'h00000010, "user ctl write");
    $display("test user mode done");
    finish_test();
  end
endmodule
